// File: rtl/swdc_pkg.sv
// Constants and types for the sleep and watchdog controller.
// Assumes one 20 MHz clock; pins arrive unsynchronised.
//
// How it works
// - STOP gates CPU clock and crystal oscillator
// - Low recovery pin in STOP starts reset
// - Fetch resumes at 000C after reset
// - Stop recovery keeps port mode register
// - Recovery pin sensed even when an output
// - First 5F enables, later ones clear
// - Enabled watchdog cannot be disabled
// - Watchdog opcode sets Z, clears S, V
// - Terminal count without refresh causes reset
// - Watchdog reset equals power-on sequence
// - Software watchdog halts during STOP
// - 4F keeps watchdog counting in HALT
// - 4F before enable does nothing
// - Permanent option enables watchdog after reset
// - Permanent watchdog runs in HALT, STOP
// - Low voltage forces reset
// - HALT stops CPU clock; interrupt wakes
// - POR timer triggered by all reset causes
// - Watchdog counts RC oscillator ticks
`default_nettype none
package swdc_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned XTAL_CYCLES = 18;
  localparam int unsigned POR_TICKS_DEF = 64;
  localparam int unsigned WDT_TERM_DEF = 1024;
  localparam int unsigned AW = 12;
  localparam logic [7:0] P2M_IDX = 8'hF6;
  localparam logic [AW-1:0] P2M_ADDR = {2'h0, P2M_IDX, 2'h0};
  localparam logic [AW-1:0] CTRL_ADDR = 12'h000;
  localparam logic [AW-1:0] STAT_ADDR = 12'h004;
  localparam logic [7:0] P2M_RST = 8'hFF;
  localparam logic CTRL_WAKE_RST = 1'h1;
  localparam logic [7:0] OP_NOP = 8'hFF;
  localparam logic [7:0] OP_STOP = 8'h6F;
  localparam logic [7:0] OP_HALT = 8'h7F;
  localparam logic [7:0] OP_WDT = 8'h5F;
  localparam logic [7:0] OP_WDH = 8'h4F;
  localparam logic [15:0] RESET_VECTOR = 16'h000C;
  localparam logic [2:0] FLAGS_ZSV = 3'h4;
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_HALT = 5'h02,
    ST_STOP = 5'h04,
    ST_POR = 5'h08,
    ST_XTAL = 5'h10
  } swdc_state_t;
  typedef enum logic [1:0] {
    CAUSE_POWER = 2'h0,
    CAUSE_STOP = 2'h1,
    CAUSE_WDT = 2'h2,
    CAUSE_LV = 2'h3
  } swdc_cause_t;
endpackage : swdc_pkg
`default_nettype wire

// File: rtl/swdc_wdt_if.sv
// Link between the controller and its watchdog counter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface swdc_wdt_if;
  logic tick;
  logic run;
  logic refresh;
  logic timeout;
  modport ctl (output tick, output run, output refresh, input timeout);
  modport cnt (input tick, input run, input refresh, output timeout);
endinterface : swdc_wdt_if
`default_nettype wire

// File: rtl/swdc_wdt.sv
// Watchdog counter, advanced by synchronised RC oscillator ticks.
// Assumes tick is a one-cycle pulse in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module swdc_wdt #(
  parameter int unsigned TERM = 1024
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Controller side
  swdc_wdt_if.cnt w
);
  import swdc_pkg::*;
  localparam int unsigned CW = $clog2(TERM + 1);
  localparam logic [CW-1:0] LAST = CW'(TERM - 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic to_q, to_d;

  assign w.timeout = to_q;

  always_comb begin
    cnt_d = cnt_q;
    to_d = 1'b0;
    if (w.refresh) begin
      cnt_d = '0;
    end else if (w.run && w.tick) begin
      if (cnt_q == LAST) begin
        cnt_d = '0;
        to_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      to_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      to_q <= to_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_wdt_clear;
    w.refresh |=> cnt_q == '0 && !to_q;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("refresh did not clear counter");

  property p_wdt_term;
    w.run && w.tick && !w.refresh && cnt_q == LAST |=> to_q ##1 !to_q;
  endproperty
  a_wdt_term: assert property (p_wdt_term) else $error("terminal count gave no timeout");

  property p_wdt_hold;
    !w.run && !w.refresh |=> $stable(cnt_q) && !to_q;
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("stopped watchdog moved");
endmodule : swdc_wdt
`default_nettype wire

// File: rtl/swdc_top.sv
// Sleep, stop recovery and watchdog control with a Wishbone slave.
// Assumes clk keeps running in STOP; osc_en tells the pad to stop.
`timescale 1ns/1ps
`default_nettype none
module swdc_top #(
  parameter int unsigned POR_TICKS = swdc_pkg::POR_TICKS_DEF,
  parameter int unsigned WDT_TERM = swdc_pkg::WDT_TERM_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [swdc_pkg::AW-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Core opcode decoder
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic irq_req,
  output logic cpu_clk_en,
  output logic core_reset,
  output logic fetch_load,
  output logic [15:0] fetch_addr,
  output logic flag_upd,
  output logic [2:0] flag_zsv,
  // Pins and options
  input wire logic stop_recovery_pin,
  input wire logic rc_osc,
  input wire logic low_voltage,
  input wire logic perm_wdt_opt,
  output logic osc_en,
  output logic [7:0] port2_direction_mode
);
  import swdc_pkg::*;
  localparam int unsigned PW = $clog2(POR_TICKS + 1);
  localparam logic [PW-1:0] POR_LAST = PW'(POR_TICKS - 1);
  localparam logic [4:0] XTAL_LAST = 5'(XTAL_CYCLES - 1);

  swdc_wdt_if wif ();

  swdc_wdt #(.TERM(WDT_TERM)) u_wdt (
    .clk(clk),
    .resetn(resetn),
    .w(wif.cnt)
  );

  // Pin synchronisers; first stage feeds only the second
  logic [3:0] s1_q, s2_q;
  logic rc_s3_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Idle pin levels, else a false low-voltage cause follows reset
      s1_q <= 4'h1;
      s2_q <= 4'h1;
      rc_s3_q <= 1'b0;
    end else begin
      s1_q <= {perm_wdt_opt, low_voltage, rc_osc, stop_recovery_pin};
      s2_q <= s1_q;
      rc_s3_q <= s2_q[1];
    end
  end
  logic rec_s, rc_tick, lv_s, perm_s;
  assign rec_s = s2_q[0];
  assign rc_tick = s2_q[1] && !rc_s3_q;
  assign lv_s = s2_q[2];
  assign perm_s = s2_q[3];

  // Control state
  swdc_state_t st_q, st_d;
  swdc_cause_t cause_q, cause_d, go_cause;
  logic [PW-1:0] por_q, por_d;
  logic [4:0] x_q, x_d;
  logic en_q, en_d, hrun_q, hrun_d, perm_q, perm_d;
  logic osc_q, osc_d, cclk_q, cclk_d, crst_q, crst_d;
  logic fl_q, fl_d, flg_q, flg_d;
  logic go_por, refresh, pm_restore, wake_q;
  logic op_ok;

  assign op_ok = op_valid && st_q == ST_RUN;

  always_comb begin
    st_d = st_q;
    cause_d = cause_q;
    por_d = por_q;
    x_d = x_q;
    en_d = en_q;
    hrun_d = hrun_q;
    perm_d = perm_q;
    osc_d = osc_q;
    cclk_d = cclk_q;
    crst_d = crst_q;
    fl_d = 1'b0;
    flg_d = 1'b0;
    go_por = 1'b0;
    go_cause = CAUSE_POWER;
    refresh = 1'b0;
    unique case (st_q)
      ST_RUN: begin
        if (op_ok) begin
          unique case (op_code)
            OP_STOP: begin
              st_d = ST_STOP;
              osc_d = 1'b0;
              cclk_d = 1'b0;
            end
            OP_HALT: begin
              st_d = ST_HALT;
              cclk_d = 1'b0;
            end
            OP_WDT: begin
              en_d = 1'b1;
              refresh = 1'b1;
              flg_d = 1'b1;
            end
            OP_WDH: begin
              if (en_q) begin
                hrun_d = 1'b1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      ST_HALT: begin
        if (irq_req && wake_q) begin
          st_d = ST_RUN;
          cclk_d = 1'b1;
        end
      end
      ST_STOP: begin
        if (!rec_s) begin
          go_por = 1'b1;
          go_cause = CAUSE_STOP;
        end
      end
      ST_POR: begin
        if (rc_tick) begin
          if (por_q == POR_LAST) begin
            st_d = ST_XTAL;
            x_d = '0;
          end else begin
            por_d = por_q + 1'b1;
          end
        end
      end
      ST_XTAL: begin
        if (x_q == XTAL_LAST) begin
          st_d = ST_RUN;
          crst_d = 1'b0;
          fl_d = 1'b1;
          perm_d = perm_s;
          en_d = perm_s;
        end else begin
          x_d = x_q + 1'b1;
        end
      end
      default: begin
        go_por = 1'b1;
      end
    endcase
    if (wif.timeout && st_q != ST_POR && st_q != ST_XTAL) begin
      go_por = 1'b1;
      go_cause = CAUSE_WDT;
    end
    if (lv_s) begin
      go_por = 1'b1;
      go_cause = CAUSE_LV;
    end
    if (go_por) begin
      st_d = ST_POR;
      cause_d = go_cause;
      por_d = '0;
      en_d = 1'b0;
      refresh = 1'b1; // Stale count would shorten a permanent period
      hrun_d = 1'b0;
      osc_d = 1'b1;
      cclk_d = 1'b1;
      crst_d = 1'b1;
      fl_d = 1'b0;
      flg_d = 1'b0;
    end
  end

  // Stop recovery leaves port modes alone to avoid output glitches
  assign pm_restore = go_por && go_cause != CAUSE_STOP;

  // Watchdog only counts where its mode allows
  always_comb begin
    wif.tick = rc_tick;
    wif.refresh = refresh;
    unique case (st_q)
      ST_RUN: wif.run = en_q;
      ST_HALT: wif.run = en_q && (hrun_q || perm_q);
      ST_STOP: wif.run = en_q && perm_q;
      default: wif.run = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_POR;
      cause_q <= CAUSE_POWER;
      por_q <= '0;
      x_q <= '0;
      en_q <= 1'b0;
      hrun_q <= 1'b0;
      perm_q <= 1'b0;
      osc_q <= 1'b1;
      cclk_q <= 1'b1;
      crst_q <= 1'b1;
      fl_q <= 1'b0;
      flg_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cause_q <= cause_d;
      por_q <= por_d;
      x_q <= x_d;
      en_q <= en_d;
      hrun_q <= hrun_d;
      perm_q <= perm_d;
      osc_q <= osc_d;
      cclk_q <= cclk_d;
      crst_q <= crst_d;
      fl_q <= fl_d;
      flg_q <= flg_d;
    end
  end

  assign cpu_clk_en = cclk_q;
  assign osc_en = osc_q;
  assign core_reset = crst_q;
  assign fetch_load = fl_q;
  assign fetch_addr = RESET_VECTOR;
  assign flag_upd = flg_q;
  assign flag_zsv = FLAGS_ZSV;

  // Wishbone slave: ack one cycle after request
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [7:0] p2m_q, p2m_d;
  logic wake_d, wr, wr_p2;
  assign wr = wb_cyc && wb_stb && wb_we && ack_q;
  assign wr_p2 = wr && wb_sel[0] && wb_adr == P2M_ADDR;

  always_comb begin
    ack_d = wb_cyc && wb_stb && !ack_q;
    dat_d = '0;
    p2m_d = p2m_q;
    wake_d = wake_q;
    if (ack_d && !wb_we) begin
      unique case (wb_adr)
        CTRL_ADDR: dat_d = {31'h0, wake_q};
        STAT_ADDR: dat_d = {22'h0, cause_q, perm_q, hrun_q, en_q, st_q};
        default: dat_d = '0;
      endcase
    end
    if (wr_p2) begin
      p2m_d = wb_dat_w[7:0];
    end
    if (wr && wb_sel[0] && wb_adr == CTRL_ADDR) begin
      wake_d = wb_dat_w[0];
    end
    if (pm_restore) begin
      p2m_d = P2M_RST;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      dat_q <= '0;
      p2m_q <= P2M_RST;
      wake_q <= CTRL_WAKE_RST;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      p2m_q <= p2m_d;
      wake_q <= wake_d;
    end
  end

  assign wb_ack = ack_q;
  assign wb_dat_r = dat_q;
  assign port2_direction_mode = p2m_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_stop_entry;
    op_ok && op_code == OP_STOP && !lv_s && !wif.timeout |=> st_q == ST_STOP && !osc_en && !cpu_clk_en;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("STOP did not gate clocks");

  property p_stop_rec;
    st_q == ST_STOP && !rec_s |=> st_q == ST_POR && core_reset && osc_en;
  endproperty
  a_stop_rec: assert property (p_stop_rec) else $error("recovery pin ignored");

  property p_vector;
    $fell(core_reset) |-> fetch_load && fetch_addr == RESET_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector load on reset exit");

  property p_keep_modes;
    st_q == ST_STOP && !rec_s && !lv_s && !wif.timeout && !wr_p2 |=> $stable(port2_direction_mode);
  endproperty
  a_keep_modes: assert property (p_keep_modes) else $error("port modes lost on recovery");

  property p_first_wdt;
    op_ok && op_code == OP_WDT && !lv_s && !wif.timeout |=> en_q && flag_upd && flag_zsv == 3'h4;
  endproperty
  a_first_wdt: assert property (p_first_wdt) else $error("watchdog opcode mishandled");

  property p_no_disable;
    en_q && !go_por |=> en_q;
  endproperty
  a_no_disable: assert property (p_no_disable) else $error("watchdog was disabled");

  property p_xtal_len;
    $rose(st_q == ST_XTAL) |-> ##18 (!core_reset || st_q == ST_POR);
  endproperty
  a_xtal_len: assert property (p_xtal_len) else $error("crystal delay not 18 cycles");

  property p_wdh_early;
    op_ok && op_code == OP_WDH && !en_q && !lv_s |=> !hrun_q;
  endproperty
  a_wdh_early: assert property (p_wdh_early) else $error("HALT_WATCHDOG_RUN_OP acted before enable");

  property p_perm_run;
    en_q && perm_q && (st_q == ST_HALT || st_q == ST_STOP) |-> wif.run;
  endproperty
  a_perm_run: assert property (p_perm_run) else $error("permanent watchdog stopped");

  property p_lv;
    lv_s |=> st_q == ST_POR && core_reset;
  endproperty
  a_lv: assert property (p_lv) else $error("low voltage gave no reset");

  c_stop_rec: cover property (st_q == ST_STOP ##1 st_q == ST_POR && cause_q == CAUSE_STOP);
  c_wdt_rst: cover property (wif.timeout ##1 cause_q == CAUSE_WDT);
  c_halt_wake: cover property (st_q == ST_HALT ##1 st_q == ST_RUN);
endmodule : swdc_top
`default_nettype wire

// File: dv/swdc_core_model.sv
// Core decoder stand-in that issues sleep and watchdog opcodes.
// Assumes the bench calls issue only while the core is running.
`timescale 1ns/1ps
`default_nettype none
module swdc_core_model (
  // Clock and core state
  input wire logic clk,
  input wire logic core_reset,
  input wire logic cpu_clk_en,
  // Opcode strobe
  output logic op_valid,
  output logic [7:0] op_code
);
  import swdc_pkg::*;
  initial begin
    op_valid = 1'h0;
    op_code = 8'h00;
  end
  // A held or sleeping core executes nothing
  task automatic issue(input logic [7:0] op);
    @(posedge clk);
    if (core_reset || !cpu_clk_en) begin
      return;
    end
    op_valid <= 1'h1;
    op_code <= OP_NOP;
    @(posedge clk);
    op_code <= op;
    @(posedge clk);
    op_valid <= 1'h0;
    // Idle bus shows no stale opcode
    op_code <= ~op;
  endtask : issue
endmodule : swdc_core_model
`default_nettype wire

// File: dv/tb.sv
// Bench for the sleep and watchdog controller: bus, opcodes, pins.
// Assumes short POR and watchdog counts to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import swdc_pkg::*;
  logic clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack, op_valid, irq_req;
  logic cpu_clk_en, core_reset, fetch_load, flag_upd, osc_en;
  logic stop_recovery_pin, rc_osc, low_voltage, perm_wdt_opt;
  logic [AW-1:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, rd_q;
  logic [7:0] op_code, port2_direction_mode;
  logic [15:0] fetch_addr;
  logic [2:0] flag_zsv;
  int mismatches, comparisons, rc_cnt;

  swdc_top #(.POR_TICKS(4), .WDT_TERM(8)) swdc_top_inst (
    .clk(clk), .resetn(resetn), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .op_valid(op_valid), .op_code(op_code), .irq_req(irq_req),
    .cpu_clk_en(cpu_clk_en), .core_reset(core_reset), .fetch_load(fetch_load),
    .fetch_addr(fetch_addr), .flag_upd(flag_upd), .flag_zsv(flag_zsv),
    .stop_recovery_pin(stop_recovery_pin), .rc_osc(rc_osc), .low_voltage(low_voltage),
    .perm_wdt_opt(perm_wdt_opt), .osc_en(osc_en), .port2_direction_mode(port2_direction_mode)
  );
  swdc_core_model swdc_core_model_inst (
    .clk(clk), .core_reset(core_reset), .cpu_clk_en(cpu_clk_en),
    .op_valid(op_valid), .op_code(op_code)
  );

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Free running RC oscillator, 8 clk per period
  always @(posedge clk) begin
    rc_cnt <= (rc_cnt == 3) ? 0 : rc_cnt + 1;
    if (rc_cnt == 3) begin
      rc_osc <= ~rc_osc;
    end
  end

  task automatic close_out();
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_up(input bit ok);
    if (!ok) begin
      mismatches++;
      $display("MISMATCH t=%0t wait ran out", $time);
      close_out();
    end
  endtask : give_up
  task automatic wb(input logic we, input logic [AW-1:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= we;
    wb_sel <= 4'h1;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'h1 && n < 20);
    give_up(wb_ack === 1'h1);
    rd_q = wb_dat_r;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_we <= 1'h0;
  endtask : wb
  task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(rd_q, e);
  endtask : rd
  task automatic wait_rst(input logic lvl, input int max);
    int n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (core_reset !== lvl && n < max);
    give_up(core_reset === lvl);
  endtask : wait_rst
  // Sleep, then wake through a pending interrupt
  task automatic halt_wake(input int cycles);
    swdc_core_model_inst.issue(OP_HALT);
    #1;
    chk(cpu_clk_en, 32'h0);
    repeat (cycles) @(posedge clk);
    irq_req <= 1'h1;
    chk({cpu_clk_en, core_reset}, 32'h0);
    @(posedge clk);
    irq_req <= 1'h0;
    #1;
    chk(cpu_clk_en, 32'h1);
  endtask : halt_wake

  initial begin
    {resetn, wb_cyc, wb_stb, wb_we, irq_req, low_voltage, perm_wdt_opt, rc_osc} = 8'h00;
    {wb_adr, wb_dat_w, rc_cnt, mismatches, comparisons} = '0;
    wb_sel = 4'h1;
    stop_recovery_pin = 1'h1;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    wait_rst(1'h0, 400);
    chk({fetch_load, fetch_addr}, 32'h1000C);
    rd(CTRL_ADDR, 32'h1);
    rd(P2M_ADDR, 32'h0);
    rd(12'h100, 32'h0);
    swdc_core_model_inst.issue(OP_WDH);
    rd(STAT_ADDR, 32'h001);
    halt_wake(100);
    swdc_core_model_inst.issue(OP_WDT);
    #1;
    chk({flag_upd, flag_zsv}, 32'hC);
    rd(STAT_ADDR, 32'h021);
    repeat (5) begin
      repeat (16) @(posedge clk);
      swdc_core_model_inst.issue(OP_WDT);
    end
    chk(core_reset, 32'h0);
    halt_wake(150);
    swdc_core_model_inst.issue(OP_WDT);
    swdc_core_model_inst.issue(OP_WDH);
    rd(STAT_ADDR, 32'h061);
    wr_p2m(32'h85);
    swdc_core_model_inst.issue(OP_HALT);
    wait_rst(1'h1, 400);
    chk(port2_direction_mode, 32'hFF);
    wait_rst(1'h0, 400);
    rd(STAT_ADDR, 32'h201);
    // Recovery pin left as output on purpose
    wr_p2m(32'h05);
    swdc_core_model_inst.issue(OP_WDT);
    swdc_core_model_inst.issue(OP_STOP);
    #1;
    chk({osc_en, cpu_clk_en}, 32'h0);
    repeat (150) @(posedge clk);
    stop_recovery_pin <= 1'h0;
    chk(core_reset, 32'h0);
    wait_rst(1'h1, 5);
    @(posedge clk);
    stop_recovery_pin <= 1'h1;
    wait_rst(1'h0, 400);
    chk({fetch_load, fetch_addr}, 32'h1000C);
    chk(port2_direction_mode, 32'h05);
    rd(STAT_ADDR, 32'h101);
    @(posedge clk);
    low_voltage <= 1'h1;
    wait_rst(1'h1, 5);
    repeat (20) @(posedge clk);
    low_voltage <= 1'h0;
    wait_rst(1'h0, 400);
    chk(port2_direction_mode, 32'hFF);
    rd(STAT_ADDR, 32'h301);
    @(posedge clk);
    perm_wdt_opt <= 1'h1;
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    wait_rst(1'h0, 400);
    rd(STAT_ADDR, 32'h0A1);
    swdc_core_model_inst.issue(OP_STOP);
    wait_rst(1'h1, 400);
    wait_rst(1'h0, 400);
    rd(STAT_ADDR, 32'h2A1);
    close_out();
  end
  task automatic wr_p2m(input logic [31:0] d);
    wb(1'h1, P2M_ADDR, d);
    #1;
    chk(port2_direction_mode, d);
  endtask : wr_p2m
endmodule : tb
`default_nettype wire
